// [pss_ctrl.v]
/*
 * pss_ctrl.v: auxiliary motor staging and sleep/wake controller with
 * an Avalon-MM register slave.
 * Assumes REF_CLK at 100 MHz, synchronous SYS_RST, and frequency inputs
 * in 0.01 Hz units synchronous to REF_CLK.
 */
`timescale 1ns/100ps
`include "pss_defines.vh"

//
// Behaviour
// - The aux motor count is how many output terminals carry aux codes, at most three.
// - Aux motors stop in the same order they started, earliest first.
// - A zero aux start frequency never lets any aux motor start.
// - Sleep is entered after output frequency stays at/below sleep frequency past detection time.
// - Sleep is left once the command stays above wake frequency past detection time.
// - The PID command is tracked during sleep and waking pulses WAKE_RAMP for one cycle.
// - PID between minimum and lower bound gives zero while in the sleep state, else lower bound.
// - PID below minimum with sleep enabled and conditions met gives zero output and sleep.
// - PID below minimum with low output but detection time pending commands the lower bound.
// - PID below minimum with sleep disabled drives output to zero.
module pss_ctrl #(
  parameter FW       = 16,
  parameter TW       = 16,
  parameter TICK_DIV = `PSS_TICK_CYCLES
) (
  input  wire          REF_CLK,
  input  wire          SYS_RST,
  input  wire          CLK_EN,
  input  wire [7:0]    AVS_ADDRESS,
  input  wire          AVS_READ,
  input  wire          AVS_WRITE,
  input  wire [31:0]   AVS_WRITEDATA,
  output reg  [31:0]   AVS_READDATA,
  output reg           AVS_WAITREQUEST,
  input  wire [FW-1:0] PID_FREQ,
  input  wire [FW-1:0] OUTPUT_FREQ,
  output reg  [FW-1:0] FREQ_COMMAND,
  output reg           SLEEP_ACTIVE,
  output reg           WAKE_RAMP,
  output reg  [3:0]    AUX_TERMINAL
);
  reg  [1:0]    ctrl;
  reg  [FW-1:0] aux_start_frequency;
  reg  [FW-1:0] aux_stop_frequency;
  reg  [TW-1:0] aux_start_delay;
  reg  [TW-1:0] aux_stop_delay;
  reg  [TW-1:0] sleep_wake_detect_time;
  reg  [FW-1:0] sleep_frequency;
  reg  [FW-1:0] wake_frequency;
  reg  [FW-1:0] minimum_output_frequency;
  reg  [FW-1:0] lower_bound;
  reg  [19:0]   out_cfg;
  reg  [31:0]   tick_count;
  reg           tick;
  reg  [2:0]    aux_on;
  reg  [1:0]    next_slot;
  reg  [1:0]    oldest;
  reg  [1:0]    state;
  reg           answered;
  reg  [1:0]    aux_count;
  reg  [31:0]   rd_mux;
  reg  [FW-1:0] next_cmd;
  reg  [3:0]    next_term;
  integer       i;
  integer       j;
  localparam [1:0] ST_RUN   = `PSS_S_RUN;
  localparam [1:0] ST_SLEEP = `PSS_S_SLEEP;
  wire          start_done;
  wire          stop_done;
  wire          sleep_done;
  wire          wake_done;
  wire          sleep_en = ctrl[`PSS_CTRL_SLEEP_EN];
  wire          running  = ctrl[`PSS_CTRL_RUN];
  wire          out_low  = OUTPUT_FREQ <= sleep_frequency;
  wire [2:0]    on_cnt   = {2'h0, aux_on[0]} + {2'h0, aux_on[1]}
                           + {2'h0, aux_on[2]};
  wire          can_start = (aux_start_frequency != {FW{1'b0}})
                            && ({1'b0, on_cnt} < {2'h0, aux_count});
  wire          start_cond = running && (state == `PSS_S_RUN) && can_start
                             && (OUTPUT_FREQ >= aux_start_frequency);
  wire          stop_cond  = running && (on_cnt != 3'h0)
                             && (OUTPUT_FREQ <= aux_stop_frequency);
  wire          sleep_cond = running && sleep_en && (state == `PSS_S_RUN)
                             && out_low;
  wire          wake_cond  = (state == `PSS_S_SLEEP)
                             && (PID_FREQ > wake_frequency);
  wire          bus_req    = AVS_READ || AVS_WRITE;
  // each action restarts its timer: one motor per delay period
  wire          start_fire = start_done && start_cond;
  wire          stop_fire  = stop_done && stop_cond;

  // count aux-coded terminals, clamped at three
  always @* begin
    aux_count = 2'h0;
    for (i = 0; i < `PSS_TERMINALS; i = i + 1) begin
      if ((out_cfg[i*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX1 ||
           out_cfg[i*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX2 ||
           out_cfg[i*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX3) &&
          aux_count != 2'h3)
        aux_count = aux_count + 2'h1;
    end
  end

  // 0.1 s tick
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tick_count <= 32'h0;
      tick       <= 1'b0;
    end else if (CLK_EN) begin
      tick <= 1'b0;
      if (tick_count >= TICK_DIV - 1) begin
        tick_count <= 32'h0;
        tick       <= 1'b1;
      end else
        tick_count <= tick_count + 32'h1;
    end
  end

  pss_timer #(.W(TW)) u_start (
    .clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN), .tick(tick),
    .cond(start_cond && !start_fire), .limit(aux_start_delay),
    .done(start_done));
  pss_timer #(.W(TW)) u_stop (
    .clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN), .tick(tick),
    .cond(stop_cond && !stop_fire), .limit(aux_stop_delay),
    .done(stop_done));
  pss_timer #(.W(TW)) u_sleep (
    .clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN), .tick(tick),
    .cond(sleep_cond), .limit(sleep_wake_detect_time),
    .done(sleep_done));
  pss_timer #(.W(TW)) u_wake (
    .clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN), .tick(tick),
    .cond(wake_cond), .limit(sleep_wake_detect_time),
    .done(wake_done));

  // aux staging: slots fill round robin so stop order follows start order
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      aux_on    <= 3'h0;
      next_slot <= 2'h0;
      oldest    <= 2'h0;
    end else if (CLK_EN) begin
      if (!running) begin
        aux_on    <= 3'h0;
        next_slot <= 2'h0;
        oldest    <= 2'h0;
      end else if (start_fire) begin
        aux_on[next_slot] <= 1'b1;
        next_slot <= (next_slot == 2'h2) ? 2'h0 : next_slot + 2'h1;
      end else if (stop_fire) begin
        aux_on[oldest] <= 1'b0;
        oldest <= (oldest == 2'h2) ? 2'h0 : oldest + 2'h1;
      end
    end
  end

  // sleep state
  always @(posedge REF_CLK) begin
    if (SYS_RST)
      state <= ST_RUN;
    else if (CLK_EN) begin
      case (state)
        ST_RUN:
          if (sleep_done && sleep_cond)
            state <= ST_SLEEP;
        ST_SLEEP:
          if (wake_done && wake_cond)
            state <= ST_RUN;
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // frequency command selection
  always @* begin
    next_cmd = PID_FREQ;
    if (state == `PSS_S_SLEEP)
      next_cmd = {FW{1'b0}};
    else if (PID_FREQ < minimum_output_frequency) begin
      if (!sleep_en)
        next_cmd = {FW{1'b0}};
      else
        next_cmd = lower_bound;
    end else if (PID_FREQ <= lower_bound)
      next_cmd = lower_bound;
    if (!running)
      next_cmd = {FW{1'b0}};
  end

  always @* begin
    next_term = 4'h0;
    for (j = 0; j < `PSS_TERMINALS; j = j + 1) begin
      if (out_cfg[j*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX1)
        next_term[j] = aux_on[0];
      else if (out_cfg[j*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX2)
        next_term[j] = aux_on[1];
      else if (out_cfg[j*`PSS_CODE_W +: `PSS_CODE_W] == `PSS_CODE_AUX3)
        next_term[j] = aux_on[2];
    end
  end

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      FREQ_COMMAND <= {FW{1'b0}};
      SLEEP_ACTIVE <= 1'b0;
      WAKE_RAMP    <= 1'b0;
      AUX_TERMINAL <= 4'h0;
    end else if (CLK_EN) begin
      FREQ_COMMAND <= next_cmd;
      SLEEP_ACTIVE <= (state == `PSS_S_SLEEP);
      // ramp request held for one cycle as sleep ends; pid keeps running
      WAKE_RAMP    <= (state == `PSS_S_SLEEP) && wake_done
                      && wake_cond;
      AUX_TERMINAL <= next_term;
    end
  end

  always @* begin
    case (AVS_ADDRESS)
      `PSS_REG_CTRL:        rd_mux = {30'h0, ctrl};
      `PSS_REG_START_FREQ:  rd_mux = {{(32-FW){1'b0}}, aux_start_frequency};
      `PSS_REG_STOP_FREQ:   rd_mux = {{(32-FW){1'b0}}, aux_stop_frequency};
      `PSS_REG_START_DLY:   rd_mux = {{(32-TW){1'b0}}, aux_start_delay};
      `PSS_REG_STOP_DLY:    rd_mux = {{(32-TW){1'b0}}, aux_stop_delay};
      `PSS_REG_DETECT_TIME: rd_mux = {{(32-TW){1'b0}},
                                      sleep_wake_detect_time};
      `PSS_REG_SLEEP_FREQ:  rd_mux = {{(32-FW){1'b0}}, sleep_frequency};
      `PSS_REG_WAKE_FREQ:   rd_mux = {{(32-FW){1'b0}}, wake_frequency};
      `PSS_REG_MIN_FREQ:    rd_mux = {{(32-FW){1'b0}},
                                      minimum_output_frequency};
      `PSS_REG_LOWER_BOUND: rd_mux = {{(32-FW){1'b0}}, lower_bound};
      `PSS_REG_OUT_CFG:     rd_mux = {12'h0, out_cfg};
      `PSS_REG_STATUS:      rd_mux = {22'h0, aux_count, 1'b0, aux_on,
                                      2'h0, WAKE_RAMP,
                                      (state == `PSS_S_SLEEP)};
      default:              rd_mux = 32'h0;
    endcase
  end

  // one wait cycle, then answer; unmapped reads give zero
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0;
      answered        <= 1'b0;
      ctrl            <= 2'h0;
      aux_start_frequency      <= {FW{1'b0}};
      aux_stop_frequency       <= {FW{1'b0}};
      aux_start_delay          <= {TW{1'b0}};
      aux_stop_delay           <= {TW{1'b0}};
      sleep_wake_detect_time   <= {TW{1'b0}};
      sleep_frequency          <= {FW{1'b0}};
      wake_frequency           <= {FW{1'b0}};
      minimum_output_frequency <= {FW{1'b0}};
      lower_bound              <= {FW{1'b0}};
      out_cfg                  <= 20'h0;
    end else if (CLK_EN) begin
      AVS_WAITREQUEST <= 1'b1;
      answered        <= 1'b0;
      if (bus_req && !answered && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        answered        <= 1'b1;
        AVS_READDATA    <= AVS_READ ? rd_mux : 32'h0;
        if (AVS_WRITE) begin
          case (AVS_ADDRESS)
            `PSS_REG_CTRL:        ctrl <= AVS_WRITEDATA[1:0];
            `PSS_REG_START_FREQ:  aux_start_frequency <= AVS_WRITEDATA[FW-1:0];
            `PSS_REG_STOP_FREQ:   aux_stop_frequency <= AVS_WRITEDATA[FW-1:0];
            `PSS_REG_START_DLY:   aux_start_delay <= AVS_WRITEDATA[TW-1:0];
            `PSS_REG_STOP_DLY:    aux_stop_delay <= AVS_WRITEDATA[TW-1:0];
            `PSS_REG_DETECT_TIME: sleep_wake_detect_time <=
                                    AVS_WRITEDATA[TW-1:0];
            `PSS_REG_SLEEP_FREQ:  sleep_frequency <= AVS_WRITEDATA[FW-1:0];
            `PSS_REG_WAKE_FREQ:   wake_frequency <= AVS_WRITEDATA[FW-1:0];
            `PSS_REG_MIN_FREQ:    minimum_output_frequency <=
                                    AVS_WRITEDATA[FW-1:0];
            `PSS_REG_LOWER_BOUND: lower_bound <= AVS_WRITEDATA[FW-1:0];
            `PSS_REG_OUT_CFG:     out_cfg <= AVS_WRITEDATA[19:0];
            default:              ctrl <= ctrl;
          endcase
        end
      end
    end
  end
endmodule

// [pss_defines.vh]
/*
 * pss_defines.vh: register map, field layout and timing constants for the
 * auxiliary motor staging and sleep/wake controller.
 * Assumes inclusion by bare name from design files in the same folder.
 */
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// register byte addresses (word aligned)
`define PSS_REG_CTRL        8'h00
`define PSS_REG_START_FREQ  8'h04
`define PSS_REG_STOP_FREQ   8'h08
`define PSS_REG_START_DLY   8'h0c
`define PSS_REG_STOP_DLY    8'h10
`define PSS_REG_DETECT_TIME 8'h14
`define PSS_REG_SLEEP_FREQ  8'h18
`define PSS_REG_WAKE_FREQ   8'h1c
`define PSS_REG_MIN_FREQ    8'h20
`define PSS_REG_LOWER_BOUND 8'h24
`define PSS_REG_OUT_CFG     8'h28
`define PSS_REG_STATUS      8'h2c

// control fields
`define PSS_CTRL_SLEEP_EN   0
`define PSS_CTRL_RUN        1

// output terminal function codes for auxiliary motors
`define PSS_CODE_AUX1       5'h10
`define PSS_CODE_AUX2       5'h11
`define PSS_CODE_AUX3       5'h12
`define PSS_CODE_W          5
`define PSS_TERMINALS       4

// status fields
`define PSS_ST_SLEEP        0
`define PSS_ST_WAKING       1
`define PSS_ST_ON_LSB       4
`define PSS_ST_CNT_LSB      8

// timing: 0.1 s tick at the system clock
`define PSS_CLK_HZ          100000000
`define PSS_TICK_SEC_TENTHS 1
`define PSS_TICK_CYCLES     (`PSS_CLK_HZ / 10 * `PSS_TICK_SEC_TENTHS)

// sleep state machine
`define PSS_S_RUN           2'h0
`define PSS_S_SLEEP         2'h1

`define PSS_BUS_READ_LAT    1'b1
`endif

// [pss_timer.v]
/*
 * pss_timer.v: qualified-condition timer counting tenths of a second.
 * Assumes a one-cycle tick every 0.1 s and a synchronous reset.
 */
`timescale 1ns/100ps
module pss_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         tick,
  input  wire         cond,
  input  wire [W-1:0] limit,
  output reg          done
);
  reg [W-1:0] count;

  always @(posedge clk) begin
    if (rst) begin
      count <= {W{1'b0}};
      done  <= 1'b0;
    end else if (ce) begin
      if (!cond) begin
        // restart whenever the entry condition lapses
        count <= {W{1'b0}};
        done  <= 1'b0;
      end else if (tick && !done) begin
        if (count >= limit)
          done <= 1'b1;
        else
          count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [pss_ctrl_properties.sv]
/*
 * pss_ctrl_properties.sv: port-level checker for pss_ctrl.
 * Assumes one clock domain REF_CLK with synchronous active-high SYS_RST.
 */
`timescale 1ns/100ps
module pss_ctrl_chk #(
  parameter FW = 16
) (
  input wire logic          REF_CLK,
  input wire logic          SYS_RST,
  input wire logic          CLK_EN,
  input wire logic          AVS_READ,
  input wire logic          AVS_WRITE,
  input wire logic [31:0]   AVS_READDATA,
  input wire logic          AVS_WAITREQUEST,
  input wire logic [FW-1:0] FREQ_COMMAND,
  input wire logic          SLEEP_ACTIVE,
  input wire logic          WAKE_RAMP,
  input wire logic [3:0]    AUX_TERMINAL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  AST_WAIT_ONE: assert property
    (!AVS_WAITREQUEST && CLK_EN |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_CAUSE: assert property
    ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without a request");
  AST_RDATA_HIGH: assert property
    (!AVS_WAITREQUEST |-> AVS_READDATA[31:20] == 12'h000)
    else $error("read data upper bits not zero");
  AST_SLEEP_ZERO: assert property
    (SLEEP_ACTIVE && $past(SLEEP_ACTIVE) |-> FREQ_COMMAND == '0)
    else $error("command not zero while asleep");
  AST_WAKE_PULSE: assert property (WAKE_RAMP && CLK_EN |=> !WAKE_RAMP)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_FROM_SLEEP: assert property
    ($rose(WAKE_RAMP) |-> $past(SLEEP_ACTIVE) || $past(SLEEP_ACTIVE, 2))
    else $error("wake pulse without prior sleep");
  AST_FREEZE: assert property (!CLK_EN |=> $stable(AUX_TERMINAL)
    && $stable(SLEEP_ACTIVE) && $stable(FREQ_COMMAND))
    else $error("state moved with clock enable low");
  AST_AUX_STEP: assert property
    ($countones(AUX_TERMINAL) <= $countones($past(AUX_TERMINAL)) + 1)
    else $error("more than one aux motor started at once");
  AST_AUX_LIMIT: assert property ($countones(AUX_TERMINAL) <= 3)
    else $error("more than three aux motors on");
  AST_AUX_SPACED: assert property
    ($countones(AUX_TERMINAL) > $countones($past(AUX_TERMINAL))
     |=> $countones(AUX_TERMINAL) <= $countones($past(AUX_TERMINAL)))
    else $error("aux motors started on consecutive cycles");
endmodule

bind pss_ctrl pss_ctrl_chk #(.FW(FW)) u_pss_ctrl_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FREQ_COMMAND(FREQ_COMMAND), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .WAKE_RAMP(WAKE_RAMP), .AUX_TERMINAL(AUX_TERMINAL));

// [pss_contactors.sv]
/*
 * pss_contactors.sv: model of the aux motor contactors on the terminals.
 * Assumes coils sampled on the system clock; counts out-of-order drops.
 */
`timescale 1ns/100ps
module pss_contactors (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] coil,
  output int             faults
);
  int         order[$];
  logic [3:0] last;
  always @(posedge clk) begin
    if (rst) begin
      order.delete();
      faults <= 0;
      last <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (coil[i] && !last[i])
          order.push_back(i);
        // earliest closed contactor must be first to open
        if (!coil[i] && last[i]) begin
          if (order.size() != 0 && order[0] == i)
            void'(order.pop_front());
          else begin
            faults <= faults + 1;
            order.delete();
          end
        end
      end
      last <= coil;
    end
  end
endmodule

// [pss_ctrl_tb.sv]
/*
 * pss_ctrl_tb.sv: self-checking bench for pss_ctrl.
 * Assumes the design sources and the checker are compiled alongside.
 */
`timescale 1ns/100ps
module pss_ctrl_tb;
  logic        clk = 0, rst = 1, en = 1, rd = 0, wr = 0, wreq, slp, wake;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0, rdata, q;
  logic [15:0] pid = 0, fout = 0, cmd;
  logic [3:0]  aux;
  int          err_total = 0, comparisons = 0, faults, n;

  always #5 clk = ~clk;

  // tick every 10 cycles keeps 0.1 s timers short
  pss_ctrl #(.TICK_DIV(10)) u_pss_ctrl (.REF_CLK(clk), .SYS_RST(rst),
    .CLK_EN(en), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .PID_FREQ(pid), .OUTPUT_FREQ(fout), .FREQ_COMMAND(cmd),
    .SLEEP_ACTIVE(slp), .WAKE_RAMP(wake), .AUX_TERMINAL(aux));
  pss_contactors u_pss_contactors (.clk(clk), .rst(rst), .coil(aux),
    .faults(faults));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after an edge; trailing edge gives the idle cycle
  task acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    adr <= a; wr <= w; rd <= !w; wd <= d; n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    q = rdata;
    rd <= 0; wr <= 0;
    @(posedge clk);
  endtask
  task w(input logic [7:0] a, input logic [31:0] d); acc(a, 1, d); endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    acc(a, 0, 0);
    chk(q, e);
  endtask
  task aux_next(input logic [3:0] prev, input logic [3:0] e);
    for (n = 0; n < 500 && aux === prev; n++) @(posedge clk);
    chk(aux, e);
  endtask

  task t_regs;
    w(8'h04, 5000);
    rchk(8'h04, 5000);
    rchk(8'h30, 0);
    w(8'h28, 32'h4a30);
    w(8'h2c, 32'hffff);
    rchk(8'h2c, 32'h300);
    $display("test regs done");
  endtask

  task t_aux;
    w(8'h08, 2000);
    w(8'h0c, 1);
    w(8'h10, 1);
    w(8'h00, 2);
    fout <= 6000;
    aux_next(0, 1);
    repeat (5) @(posedge clk);
    chk(aux, 1);
    aux_next(1, 3);
    aux_next(3, 7);
    en <= 0;
    repeat (30) @(posedge clk);
    chk(aux, 7);
    en <= 1;
    fout <= 1000;
    aux_next(7, 6);
    aux_next(6, 4);
    aux_next(4, 0);
    chk(faults, 0);
    w(8'h04, 0);
    fout <= 6000;
    repeat (100) @(posedge clk);
    chk(aux, 0);
    $display("test aux done");
  endtask

  task t_sleep;
    fout <= 800;
    pid <= 300;
    w(8'h18, 1000);
    w(8'h1c, 3000);
    w(8'h20, 500);
    w(8'h24, 1500);
    w(8'h14, 5);
    w(8'h00, 3);
    repeat (10) @(posedge clk);
    chk(cmd, 1500);
    for (n = 0; n < 500 && slp !== 1'b1; n++) @(posedge clk);
    chk(slp, 1);
    repeat (2) @(posedge clk);
    chk(cmd, 0);
    pid <= 4000;
    for (n = 0; n < 500 && wake !== 1'b1; n++) @(posedge clk);
    chk(wake, 1);
    repeat (2) @(posedge clk);
    chk(slp, 0);
    w(8'h00, 2);
    pid <= 300;
    repeat (5) @(posedge clk);
    chk(cmd, 0);
    pid <= 1000;
    repeat (5) @(posedge clk);
    chk(cmd, 1500);
    $display("test sleep done");
  endtask

  task results;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    results;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_aux;
    t_sleep;
    results;
  end
endmodule
